/* bcae_pkg.sv */
// Constants, opcodes and state codes shared by the branch, call and add execution core
// ****************************************************************
// ****************************************************************
package bcae_pkg;

  // ****************************************************************
  // Reset values and special register addresses
  // ****************************************************************
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [3:0] BIT_AREA_BASE = 4'h2;

  // ****************************************************************
  // Status word bit positions
  // ****************************************************************
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;

  // ****************************************************************
  // Opcodes, full bytes and masked groups
  // ****************************************************************
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_ADD_IMM = 8'h24;
  localparam logic [7:0] OP_ADD_DIR = 8'h25;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h32;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_AI = 8'hB4;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_AD = 8'hB5;
  localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO_DIR = 8'hD5;
  localparam logic [6:0] OP_ADD_IND = 7'h13;
  localparam logic [4:0] OP_ADD_REG = 5'h05;
  localparam logic [6:0] OP_COMPARE_JUMP_UNEQUAL_IND = 7'h5B;
  localparam logic [4:0] OP_COMPARE_JUMP_UNEQUAL_REG = 5'h17;
  localparam logic [4:0] OP_DECREMENT_JUMP_NONZERO_REG = 5'h1B;
  localparam logic [4:0] OP_CALL_LOW = 5'h11;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    S_FETCH = 4'h0,
    S_OPC = 4'h1,
    S_B2 = 4'h2,
    S_B3 = 4'h3,
    S_ADDR = 4'h4,
    S_IND = 4'h5,
    S_RD = 4'h6,
    S_EXEC = 4'h7,
    S_PUSH1 = 4'h8,
    S_PUSH2 = 4'h9,
    S_POP1 = 4'hA,
    S_POP2 = 4'hB,
    S_POP3 = 4'hC
  } bcae_state_e;

endpackage : bcae_pkg

/* bcae_adder.sv */
// Byte adder with carry, auxiliary carry and overflow generation
`timescale 1ns/100ps
`default_nettype none
module bcae_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  output logic [WIDTH-1:0] sum,
  output logic carry,
  output logic auxCarry,
  output logic overflow
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (WIDTH < 5) begin : g_bad_width
    $error("bcae_adder needs at least five bits");
  end

  logic [WIDTH:0] full;
  logic [WIDTH-1:0] low;
  logic [4:0] nib;

  // Partial sums give the carries out of bit 3 and the bit below the top
  assign full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
  assign low = {1'b0, a[WIDTH-2:0]} + {1'b0, b[WIDTH-2:0]} + {{(WIDTH-1){1'b0}}, cin};
  assign nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

  // Flags from the carry chain
  assign sum = full[WIDTH-1:0];
  assign carry = full[WIDTH];
  assign auxCarry = nib[4];
  assign overflow = full[WIDTH] ^ low[WIDTH-1];

endmodule : bcae_adder
`default_nettype wire

/* bcae_core.sv */
// Execution core for relative jumps, interrupt return, absolute call and byte add
`timescale 1ns/100ps
`default_nettype none
module bcae_core (
  input wire logic clk,
  input wire logic rst_n,
  output logic [15:0] codeAddr,
  input wire logic [7:0] codeData,
  output logic [7:0] dataAddr,
  output logic [7:0] dataWdata,
  output logic dataWe,
  output logic dataRe,
  input wire logic [7:0] dataRdata,
  output logic [15:0] pc,
  output logic [7:0] acc,
  output logic [7:0] sp,
  output logic [7:0] statusWord,
  output logic irqRelease,
  output logic unknownOp,
  output logic instrDone
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Instruction length from the raw opcode byte
  function automatic logic [1:0] opLen(input logic [7:0] op);
    logic [1:0] n;
    n = 2'd1;
    if (op == bcae_pkg::OP_JBC || op == bcae_pkg::OP_JB || op == bcae_pkg::OP_JNB ||
        op == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_AI || op == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_AD || op == bcae_pkg::OP_DECREMENT_JUMP_NONZERO_DIR ||
        op[7:1] == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_IND || op[7:3] == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_REG) begin
      n = 2'd3;
    end else if (op == bcae_pkg::OP_JZ || op == bcae_pkg::OP_JNZ || op == bcae_pkg::OP_JC ||
                 op == bcae_pkg::OP_JNC || op == bcae_pkg::OP_SJMP || op == bcae_pkg::OP_ADD_IMM ||
                 op == bcae_pkg::OP_ADD_DIR || op[4:0] == bcae_pkg::OP_CALL_LOW ||
                 op[7:3] == bcae_pkg::OP_DECREMENT_JUMP_NONZERO_REG) begin
      n = 2'd2;
    end
    return n;
  endfunction : opLen

  // Working register address in the selected bank
  function automatic logic [7:0] regAddr(input logic [1:0] bank, input logic [2:0] r);
    return {3'b000, bank, r};
  endfunction : regAddr

  // Byte holding a directly addressed bit
  function automatic logic [7:0] bitByte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'b000} : {bcae_pkg::BIT_AREA_BASE, b[6:3]};
  endfunction : bitByte

  // Direct addresses served by the core's own registers
  function automatic logic sfrHit(input logic [7:0] a);
    return a == bcae_pkg::ADDR_ACC || a == bcae_pkg::ADDR_PSW || a == bcae_pkg::ADDR_SP;
  endfunction : sfrHit

  // ****************************************************************
  // State and instruction registers
  // ****************************************************************
  bcae_pkg::bcae_state_e state;
  bcae_pkg::bcae_state_e next_state;
  logic [7:0] opcode;
  logic [7:0] byte2;
  logic [7:0] byte3;
  logic [7:0] opnd;
  logic [7:0] rdAddr;
  logic rdSfr;
  logic [7:0] retHi;
  logic [7:0] program_status_word;

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  logic isJz, isJnz, isJc, isJnc, isJb, isJnb, isJbc, isSjmp;
  logic isCjneAi, isCjneAd, isCjneInd, isCjneReg, isCjne;
  logic isDjnzDir, isDjnzReg, isDjnz;
  logic isAddImm, isAddDir, isAddInd, isAddReg, isAdd;
  logic isCall, isReti, isBitOp, isInd, isRegMode, isLong3, isJump, isKnown;
  logic needRead;

  // Opcode classes; one-hot by construction
  assign isJz = opcode == bcae_pkg::OP_JZ;
  assign isJnz = opcode == bcae_pkg::OP_JNZ;
  assign isJc = opcode == bcae_pkg::OP_JC;
  assign isJnc = opcode == bcae_pkg::OP_JNC;
  assign isJb = opcode == bcae_pkg::OP_JB;
  assign isJnb = opcode == bcae_pkg::OP_JNB;
  assign isJbc = opcode == bcae_pkg::OP_JBC;
  assign isSjmp = opcode == bcae_pkg::OP_SJMP;
  assign isCjneAi = opcode == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_AI;
  assign isCjneAd = opcode == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_AD;
  assign isCjneInd = opcode[7:1] == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_IND;
  assign isCjneReg = opcode[7:3] == bcae_pkg::OP_COMPARE_JUMP_UNEQUAL_REG;
  assign isCjne = isCjneAi | isCjneAd | isCjneInd | isCjneReg;
  assign isDjnzDir = opcode == bcae_pkg::OP_DECREMENT_JUMP_NONZERO_DIR;
  assign isDjnzReg = opcode[7:3] == bcae_pkg::OP_DECREMENT_JUMP_NONZERO_REG;
  assign isDjnz = isDjnzDir | isDjnzReg;
  assign isAddImm = opcode == bcae_pkg::OP_ADD_IMM;
  assign isAddDir = opcode == bcae_pkg::OP_ADD_DIR;
  assign isAddInd = opcode[7:1] == bcae_pkg::OP_ADD_IND;
  assign isAddReg = opcode[7:3] == bcae_pkg::OP_ADD_REG;
  assign isAdd = isAddImm | isAddDir | isAddInd | isAddReg;
  assign isCall = opcode[4:0] == bcae_pkg::OP_CALL_LOW;
  assign isReti = opcode == bcae_pkg::OP_INTERRUPT_RETURN;

  // Addressing mode and length groups
  assign isBitOp = isJb | isJnb | isJbc;
  assign isInd = isAddInd | isCjneInd;
  assign isRegMode = isAddReg | isCjneReg | isDjnzReg;
  assign isLong3 = opLen(opcode) == 2'd3;
  assign isJump = isJz | isJnz | isJc | isJnc | isBitOp | isSjmp | isCjne | isDjnz;
  assign isKnown = isJump | isAdd | isCall | isReti;
  assign needRead = isInd | isRegMode | isAddDir | isCjneAd | isDjnzDir | isBitOp;

  // ****************************************************************
  // Operand addressing
  // ****************************************************************
  logic [1:0] bank;
  logic [7:0] opAddr;
  logic [7:0] rdValue;

  // Pointer register is R0 or R1 only, picked by opcode bit 0
  assign bank = {program_status_word[bcae_pkg::PSW_RS1], program_status_word[bcae_pkg::PSW_RS0]};
  assign opAddr = isInd ? regAddr(bank, {2'b00, opcode[0]}) :
                  isRegMode ? regAddr(bank, opcode[2:0]) :
                  isBitOp ? bitByte(byte2) : byte2;

  // Core-held registers answer direct reads instead of the data port
  assign rdValue = !rdSfr ? dataRdata :
                   rdAddr == bcae_pkg::ADDR_ACC ? acc :
                   rdAddr == bcae_pkg::ADDR_PSW ? statusWord : sp;

  // ****************************************************************
  // Execution datapath
  // ****************************************************************
  logic [7:0] relByte;
  logic [15:0] relTarget;
  logic bitVal;
  logic [7:0] decValue;
  logic [7:0] cmpA;
  logic [7:0] cmpB;
  logic taken;
  logic memWrReq;
  logic [7:0] memWrData;
  logic wrInt;
  logic [7:0] addSrc;
  logic [7:0] addSum;
  logic addCy, addAc, addOv;

  // Offset is the last instruction byte; pc already points past it
  assign relByte = isLong3 ? byte3 : byte2;
  assign relTarget = pc + {{8{relByte[7]}}, relByte};
  assign bitVal = opnd[byte2[2:0]];
  assign decValue = opnd - 8'h01;
  assign cmpA = (isCjneAi | isCjneAd) ? acc : opnd;
  assign cmpB = isCjneAd ? opnd : byte2;

  // Branch condition per instruction
  assign taken = (isJz & (acc == 8'h00)) |
                 (isJnz & (acc != 8'h00)) |
                 (isJc & program_status_word[bcae_pkg::PSW_CY]) |
                 (isJnc & ~program_status_word[bcae_pkg::PSW_CY]) |
                 ((isJb | isJbc) & bitVal) |
                 (isJnb & ~bitVal) |
                 (isCjne & (cmpA != cmpB)) |
                 (isDjnz & (decValue != 8'h00)) |
                 isSjmp;

  // Write-back: cleared bit or decremented byte, to the address that was read
  assign memWrReq = (isJbc & bitVal) | isDjnz;
  assign memWrData = isDjnz ? decValue : (opnd & ~(8'h01 << byte2[2:0]));
  assign wrInt = (state == bcae_pkg::S_EXEC) & memWrReq & rdSfr;

  // Add source by addressing mode
  assign addSrc = isAddImm ? byte2 : opnd;

  bcae_adder #(
    .WIDTH(8)
  ) u_adder (
    .a(acc),
    .b(addSrc),
    .cin(1'b0),
    .sum(addSum),
    .carry(addCy),
    .auxCarry(addAc),
    .overflow(addOv)
  );

  // ****************************************************************
  // Memory ports
  // ****************************************************************
  // Fetch address runs one ahead while operand bytes stream in
  assign codeAddr = (state == bcae_pkg::S_OPC || state == bcae_pkg::S_B2) ? pc + 16'h0001 : pc;

  // Read strobes for operand, pointer target and stack pops
  assign dataRe = (state == bcae_pkg::S_ADDR && needRead) || state == bcae_pkg::S_IND ||
                  state == bcae_pkg::S_POP1 || state == bcae_pkg::S_POP2;
  assign dataWe = state == bcae_pkg::S_PUSH1 || state == bcae_pkg::S_PUSH2 ||
                  (state == bcae_pkg::S_EXEC && memWrReq && !rdSfr);

  // Address and write data per state; SP pre-increments before each push
  always_comb begin
    case (state)
      bcae_pkg::S_ADDR: dataAddr = opAddr;
      bcae_pkg::S_IND: dataAddr = dataRdata;
      bcae_pkg::S_PUSH1, bcae_pkg::S_PUSH2: dataAddr = sp + 8'h01;
      bcae_pkg::S_POP1: dataAddr = sp;
      bcae_pkg::S_POP2: dataAddr = sp - 8'h01;
      default: dataAddr = rdAddr;
    endcase
  end

  assign dataWdata = state == bcae_pkg::S_PUSH1 ? pc[7:0] :
                     state == bcae_pkg::S_PUSH2 ? pc[15:8] : memWrData;

  // Parity is derived, never stored
  assign statusWord = {program_status_word[7:1], ^acc};

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state; every instruction ends back in fetch
  always_comb begin
    case (state)
      bcae_pkg::S_FETCH: next_state = bcae_pkg::S_OPC;
      bcae_pkg::S_OPC: next_state = opLen(codeData) == 2'd1 ? bcae_pkg::S_ADDR : bcae_pkg::S_B2;
      bcae_pkg::S_B2: next_state = isLong3 ? bcae_pkg::S_B3 : bcae_pkg::S_ADDR;
      bcae_pkg::S_B3: next_state = bcae_pkg::S_ADDR;
      bcae_pkg::S_ADDR: begin
        if (isCall) begin
          next_state = bcae_pkg::S_PUSH1;
        end else if (isReti) begin
          next_state = bcae_pkg::S_POP1;
        end else if (isInd) begin
          next_state = bcae_pkg::S_IND;
        end else if (needRead) begin
          next_state = bcae_pkg::S_RD;
        end else begin
          next_state = bcae_pkg::S_EXEC;
        end
      end
      bcae_pkg::S_IND: next_state = bcae_pkg::S_RD;
      bcae_pkg::S_RD: next_state = bcae_pkg::S_EXEC;
      bcae_pkg::S_PUSH1: next_state = bcae_pkg::S_PUSH2;
      bcae_pkg::S_POP1: next_state = bcae_pkg::S_POP2;
      bcae_pkg::S_POP2: next_state = bcae_pkg::S_POP3;
      default: next_state = bcae_pkg::S_FETCH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= bcae_pkg::S_FETCH;
    end else begin
      state <= next_state;
    end
  end

  // Instruction bytes captured as they arrive from program memory
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode <= 8'h00;
      byte2 <= 8'h00;
      byte3 <= 8'h00;
    end else begin
      if (state == bcae_pkg::S_OPC) opcode <= codeData;
      if (state == bcae_pkg::S_B2) byte2 <= codeData;
      if (state == bcae_pkg::S_B3) byte3 <= codeData;
    end
  end

  // Operand fetch; the pointer target is RAM, never a core register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdAddr <= 8'h00;
      rdSfr <= 1'b0;
      opnd <= 8'h00;
      retHi <= 8'h00;
    end else begin
      if (state == bcae_pkg::S_ADDR) begin
        rdAddr <= opAddr;
        rdSfr <= !(isInd | isRegMode) & sfrHit(opAddr);
      end else if (state == bcae_pkg::S_IND) begin
        rdAddr <= dataRdata;
        rdSfr <= 1'b0;
      end
      if (state == bcae_pkg::S_RD) opnd <= rdValue;
      if (state == bcae_pkg::S_POP2) retHi <= dataRdata;
    end
  end

  // Program counter: byte steps, relative jumps, call and return targets
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc <= bcae_pkg::PC_RESET;
    end else if (state == bcae_pkg::S_OPC || state == bcae_pkg::S_B2 || state == bcae_pkg::S_B3) begin
      pc <= pc + 16'h0001;
    end else if (state == bcae_pkg::S_EXEC && taken) begin
      pc <= relTarget;
    end else if (state == bcae_pkg::S_PUSH2) begin
      pc <= {pc[15:11], opcode[7:5], byte2};
    end else if (state == bcae_pkg::S_POP3) begin
      pc <= {retHi, dataRdata};
    end
  end

  // Accumulator: add result or a direct write-back aimed at it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= bcae_pkg::ACC_RESET;
    end else if (state == bcae_pkg::S_EXEC && isAdd) begin
      acc <= addSum;
    end else if (wrInt && rdAddr == bcae_pkg::ADDR_ACC) begin
      acc <= memWrData;
    end
  end

  // Status flags; a direct write replaces all stored bits, parity stays derived
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_status_word <= bcae_pkg::PSW_RESET;
    end else if (state == bcae_pkg::S_EXEC && isAdd) begin
      program_status_word[bcae_pkg::PSW_CY] <= addCy;
      program_status_word[bcae_pkg::PSW_AC] <= addAc;
      program_status_word[bcae_pkg::PSW_OV] <= addOv;
    end else if (state == bcae_pkg::S_EXEC && isCjne) begin
      program_status_word[bcae_pkg::PSW_CY] <= cmpA < cmpB;
    end else if (wrInt && rdAddr == bcae_pkg::ADDR_PSW) begin
      program_status_word <= memWrData;
    end
  end

  // Stack pointer: +1 per push, -2 on return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp <= bcae_pkg::SP_RESET;
    end else if (state == bcae_pkg::S_PUSH1 || state == bcae_pkg::S_PUSH2) begin
      sp <= sp + 8'h01;
    end else if (state == bcae_pkg::S_POP3) begin
      sp <= sp - 8'h02;
    end else if (wrInt && rdAddr == bcae_pkg::ADDR_SP) begin
      sp <= memWrData;
    end
  end

  // One-cycle status pulses at the end of an instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqRelease <= 1'b0;
      unknownOp <= 1'b0;
      instrDone <= 1'b0;
    end else begin
      irqRelease <= state == bcae_pkg::S_POP3;
      unknownOp <= state == bcae_pkg::S_EXEC && !isKnown;
      instrDone <= state == bcae_pkg::S_EXEC || state == bcae_pkg::S_PUSH2 || state == bcae_pkg::S_POP3;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_parity_tracks_acc: assert property (statusWord[0] == ^acc)
    else $error("parity differs from accumulator");
  a_call_push_order: assert property (state == bcae_pkg::S_PUSH1 |->
    dataWe && dataAddr == sp + 8'h01 && dataWdata == pc[7:0] ##1 dataWe && dataWdata == pc[15:8])
    else $error("call push order wrong");
  a_call_sp_step: assert property (state == bcae_pkg::S_PUSH1 |-> ##2 sp == $past(sp, 2) + 8'h02)
    else $error("call did not add two to stack pointer");
  a_call_target: assert property (state == bcae_pkg::S_PUSH2 |=>
    pc == {$past(pc[15:11]), $past(opcode[7:5]), $past(byte2)} && program_status_word == $past(program_status_word))
    else $error("call target wrong or flags changed");
  a_add_carry: assert property (state == bcae_pkg::S_EXEC && isAdd |=>
    program_status_word[bcae_pkg::PSW_CY] == (({1'b0, $past(acc)} + {1'b0, $past(addSrc)}) > 9'h0FF))
    else $error("add carry wrong");
  a_add_overflow: assert property (state == bcae_pkg::S_EXEC && isAdd |=>
    program_status_word[bcae_pkg::PSW_OV] == (($past(acc[7]) == $past(addSrc[7])) && (acc[7] != $past(acc[7]))))
    else $error("add overflow wrong");
  a_jz_branch: assert property (state == bcae_pkg::S_EXEC && isJz && acc == 8'h00 |=>
    pc == $past(relTarget))
    else $error("zero jump not taken");
  a_untaken_falls: assert property (state == bcae_pkg::S_EXEC && isJump && !taken |=>
    pc == $past(pc) && state == bcae_pkg::S_FETCH)
    else $error("untaken jump moved pc");
  a_compare_jump_unequal_carry: assert property (state == bcae_pkg::S_EXEC && isCjne |=>
    program_status_word[bcae_pkg::PSW_CY] == ($past(cmpA) < $past(cmpB)))
    else $error("compare carry wrong");
  a_jbc_clear: assert property (state == bcae_pkg::S_EXEC && isJbc && !rdSfr |->
    dataWe == bitVal && (!bitVal || !dataWdata[byte2[2:0]]))
    else $error("bit clear wrong");
  a_interrupt_return_release: assert property (state == bcae_pkg::S_POP1 |-> ##3 irqRelease && sp == $past(sp, 3) - 8'h02)
    else $error("return did not release level");

  c_call: cover property (state == bcae_pkg::S_PUSH2);
  c_interrupt_return: cover property (irqRelease);
  c_compare_jump_unequal_taken: cover property (state == bcae_pkg::S_EXEC && isCjne && taken);
  c_add_ov: cover property (state == bcae_pkg::S_EXEC && isAdd && addOv);

endmodule : bcae_core
`default_nettype wire

/* bcae_mem.sv */
// Program and data memory model facing the execution core
`timescale 1ns/100ps
`default_nettype none
module bcae_mem (
  input wire logic clk,
  input wire logic [15:0] codeAddr,
  output logic [7:0] codeData,
  input wire logic [7:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic dataWe,
  input wire logic dataRe,
  output logic [7:0] dataRdata
);
  logic [7:0] code [0:255];
  logic [7:0] ram [0:255];
  // One cycle latency; idle read bus toggles so stale data never passes
  always_ff @(posedge clk) begin
    codeData <= code[codeAddr[7:0]];
    if (dataWe) ram[dataAddr] <= dataWdata;
    dataRdata <= dataRe ? ram[dataAddr] : ~dataRdata;
  end
endmodule : bcae_mem
`default_nettype wire

/* test_branch_call_add_execute.sv */
// Self-checking bench: add, relative jumps, call and interrupt return
`timescale 1ns/100ps
`default_nettype none
module test_branch_call_add_execute;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] codeAddr;
  logic [15:0] pc;
  logic [7:0] codeData;
  logic [7:0] dataAddr;
  logic [7:0] dataWdata;
  logic [7:0] dataRdata;
  logic [7:0] acc;
  logic [7:0] sp;
  logic [7:0] statusWord;
  logic dataWe;
  logic dataRe;
  logic irqRelease;
  logic unknownOp;
  logic instrDone;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'hc232_61dd;
  bcae_core bcae_core_i (.clk(clk), .rst_n(rst_n), .codeAddr(codeAddr), .codeData(codeData),
    .dataAddr(dataAddr), .dataWdata(dataWdata), .dataWe(dataWe), .dataRe(dataRe), .dataRdata(dataRdata),
    .pc(pc), .acc(acc), .sp(sp), .statusWord(statusWord), .irqRelease(irqRelease),
    .unknownOp(unknownOp), .instrDone(instrDone));
  bcae_mem bcae_mem_i (.clk(clk), .codeAddr(codeAddr), .codeData(codeData), .dataAddr(dataAddr),
    .dataWdata(dataWdata), .dataWe(dataWe), .dataRe(dataRe), .dataRdata(dataRdata));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait for completion, then pc and pulses
  task step(input logic [15:0] epc, input logic eirq);
    int n;
    n = 0;
    while (instrDone !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(pc, epc);
    chk(irqRelease, eirq);
    chk(unknownOp, 1'b0);
    @(negedge clk);
  endtask : step
  // Program: add, add, carry jump, short jump, call, return, zero jump
  task run_one(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [7:0] lo7;
    logic [4:0] lo4;
    logic [7:0] prog [0:11];
    s = {1'b0, a} + {1'b0, b};
    lo7 = {1'b0, a[6:0]} + {1'b0, b[6:0]};
    lo4 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    prog = '{8'h24, a, 8'h24, b, 8'h40, 8'h02, 8'h80, 8'h00, 8'h11, 8'h20, 8'h60, 8'hF4};
    for (int i = 0; i < 12; i++) bcae_mem_i.code[i] = prog[i];
    bcae_mem_i.code[32] = 8'h32;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    step(16'h0002, 1'b0);
    step(16'h0004, 1'b0);
    chk(acc, s[7:0]);
    chk(statusWord[7], s[8]);
    chk(statusWord[6], lo4[4]);
    chk(statusWord[2], lo7[7] ^ s[8]);
    chk(statusWord[0], ^s[7:0]);
    step(s[8] ? 16'h0008 : 16'h0006, 1'b0);
    if (!s[8]) step(16'h0008, 1'b0);
    step(16'h0020, 1'b0);
    chk(sp, 8'h09);
    chk(bcae_mem_i.ram[8], 8'h0A);
    chk(bcae_mem_i.ram[9], 8'h00);
    step(16'h000A, 1'b1);
    step(s[7:0] == 8'h00 ? 16'h0000 : 16'h000C, 1'b0);
  endtask : run_one
  // Program: add, compare jump, decrement of acc, bit-clear jump on acc bit 0
  task run_two(input logic [7:0] v);
    logic [7:0] d;
    logic [7:0] w;
    logic [7:0] prog [0:10];
    d = v - 8'h01;
    w = v ^ 8'h01;
    prog = '{8'h24, v, 8'hB4, w, 8'h00, 8'hD5, 8'hE0, 8'h00, 8'h10, 8'hE0, 8'h03};
    for (int i = 0; i < 11; i++) bcae_mem_i.code[i] = prog[i];
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    step(16'h0002, 1'b0);
    chk(acc, v);
    step(16'h0005, 1'b0);
    chk(statusWord[7], v < w);
    chk(acc, v);
    step(16'h0008, 1'b0);
    chk(acc, d);
    step(d[0] ? 16'h000E : 16'h000B, 1'b0);
    chk(acc, d & 8'hFE);
    chk(statusWord[0], ^(d & 8'hFE));
  endtask : run_two
  task test_done();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Clock and watchdog
  initial forever #10 clk = ~clk;
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  // First pass forces a zero sum so the zero jump is taken once
  initial begin
    logic [7:0] a;
    for (int k = 0; k < 10; k++) begin
      a = $random(seed);
      run_one(a, k == 0 ? -a : 8'($random(seed)));
      run_two(a);
    end
    test_done();
  end
endmodule : test_branch_call_add_execute
`default_nettype wire
